// File: common/nfr_pkg.sv
// Purpose: constants shared by the nand read sequencer host
// Assumes: 40 MHz system clock, x8 nand data bus
// Notes: register map is one aligned 32-bit word each
package nfr_pkg;
  // ------------------------------
  // timing
  // ------------------------------
  localparam int T_CLK_NS = 25;
  localparam int T_WP_NS = 25;
  localparam int T_WH_NS = 15;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 15;
  localparam int T_WB_NS = 100;
  localparam int SYNC_STAGES = 3;

  // least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + T_CLK_NS - 1) / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] WP_CYC = 4'(cyc_up(T_WP_NS));
  localparam logic [3:0] WH_CYC = 4'(cyc_up(T_WH_NS));
  // one extra edge: the agreeing-stages register sits after the third flop
  localparam logic [3:0] RP_CYC = 4'(cyc_up(T_REA_NS) + SYNC_STAGES + 1);
  localparam logic [3:0] REH_CYC = 4'(cyc_up(T_REH_NS));
  localparam logic [3:0] WB_CYC = 4'(cyc_up(T_WB_NS));

  // ------------------------------
  // nand command codes
  // ------------------------------
  localparam logic [7:0] NC_READ = 8'h00;
  localparam logic [7:0] NC_PAGE_GO = 8'h30;
  localparam logic [7:0] NC_CACHE_GO = 8'h31;
  localparam logic [7:0] NC_CACHE_LAST = 8'h3f;
  localparam logic [7:0] NC_COL_MOVE = 8'h05;
  localparam logic [7:0] NC_PLANE_MOVE = 8'h06;
  localparam logic [7:0] NC_MOVE_GO = 8'he0;
  localparam logic [7:0] NC_STATUS = 8'h70;
  localparam logic [7:0] NC_STATUS_SEL = 8'h78;
  localparam int PLANE_SELECT_BIT = 6;
  localparam int STS_FAIL_BIT = 0;

  // ------------------------------
  // register map
  // ------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_COL = 8'h08;
  localparam logic [7:0] REG_ROW = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam int CFG_MULTI_DIE = 0;
  localparam int CFG_ECC_EN = 1;

  typedef enum logic [3:0] {
    OP_RDMODE = 4'h0, OP_PAGE = 4'h1, OP_CSEQ = 4'h2, OP_CRAND = 4'h3,
    OP_CLAST = 4'h4, OP_TWOP = 4'h5, OP_COLMV = 4'h6, OP_PLMV = 4'h7,
    OP_STAT = 4'h8, OP_ESTAT = 4'h9, OP_DATA = 4'ha, OP_ECC = 4'hb
  } nfr_op_e;

  typedef enum logic [2:0] {
    SK_END = 3'h0, SK_CMD = 3'h1, SK_ADDR = 3'h2, SK_READ = 3'h3, SK_WAIT = 3'h4
  } nfr_step_e;
endpackage

// File: verilog/nfr_sync3.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes: a bit changes once stages two and three agree
`timescale 1ns/1ps
module nfr_sync3 import nfr_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1) begin : g_chk
    $error("sync width must be positive");
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      dout <= RST_VAL;
    end else if (clk_en) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // per bit: only a settled value passes
      dout <= (s2_r & s3_r) | (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & dout);
    end
  end
endmodule

// File: verilog/nfr_bus_cycle.sv
// Purpose: one command, address or data-out cycle on the nand pins
// Assumes: dq_s is already synchronised
// Notes: strobe widths come from package cycle counts
`timescale 1ns/1ps
module nfr_bus_cycle import nfr_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // request
  input wire logic start,
  input wire logic rd,
  input wire logic is_addr,
  input wire logic [7:0] wbyte,
  output logic done,
  output logic [7:0] rbyte,
  // pins
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_s
);
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_LOW = 2'b01, PH_HIGH = 2'b11} nfr_ph_e;
  nfr_ph_e ph_r;
  logic [3:0] cnt_r;
  logic rd_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      ph_r <= PH_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      done <= 1'b0;
      rbyte <= 8'h00;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      dq_o <= 8'h00;
      dq_oe <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (ph_r)
        PH_IDLE: begin
          if (start) begin
            rd_r <= rd;
            cmd_latch <= !rd && !is_addr;
            addr_latch <= !rd && is_addr;
            dq_o <= wbyte;
            dq_oe <= !rd;
            write_strobe_n <= rd;
            output_strobe_n <= !rd;
            cnt_r <= rd ? RP_CYC : WP_CYC;
            ph_r <= PH_LOW;
          end
        end
        PH_LOW: begin
          if (cnt_r == 4'h1) begin
            // sample just before the strobe rises, after access time
            if (rd_r) begin
              rbyte <= dq_s;
            end
            write_strobe_n <= 1'b1;
            output_strobe_n <= 1'b1;
            cnt_r <= rd_r ? REH_CYC : WH_CYC;
            ph_r <= PH_HIGH;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        PH_HIGH: begin
          if (cnt_r == 4'h1) begin
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            dq_oe <= 1'b0;
            done <= 1'b1;
            ph_r <= PH_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: ph_r <= PH_IDLE;
      endcase
    end
  end
endmodule

// File: verilog/nfr_host.sv
// Purpose: host sequencer for nand page, cache and two-plane reads
// Assumes: apb software port, one die selected at a time
// Notes: software orders one operation per CTRL write
// Function
// - multi-die: enhanced status before read mode
// - page read is 00h, five addresses, 30h
// - after status polling, read mode before data
// - random data read moves output column
// - with ecc, read status after page load
// - no sequential cache across die boundary
// - cache random keeps die of prior read
// - multi-die cache reads: enhanced status, read mode
// - two-plane is two address groups then 30h
// - both plane addresses share one column
// - two-plane: plane 0 out, then 06h-E0h
// - polled two-plane needs 06h-E0h before data
// - no enhanced status around two-plane reads
// - during cache busy only status or reset
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module nfr_host import nfr_pkg::*; #(
  parameter int DIE_ROW_BITS = 18
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nand pins
  output logic chip_en_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i,
  input wire logic ready_busy_n
);
  // ------------------------------
  // checks and declarations
  // ------------------------------
  if (DIE_ROW_BITS < 1 || DIE_ROW_BITS > 23) begin : g_chk
    $error("DIE_ROW_BITS must lie in 1..23");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ISSUE = 3'b001, ST_XFER = 3'b011,
    ST_WB = 3'b010, ST_WRB = 3'b110, ST_FIN = 3'b111
  } nfr_state_e;

  nfr_state_e st_r;
  nfr_op_e op_r;
  logic [3:0] idx_r;
  logic [3:0] wb_r;
  logic [1:0] cfg_r;
  logic [15:0] col_r;
  logic [23:0] row_r;
  logic [23:0] cur_row_r;
  logic [7:0] status_r;
  logic [7:0] data_r;
  logic done_r;
  logic refused_r;
  logic ecc_fail_r;
  logic last_sel_r;
  logic stat_out_r;
  logic two_plane_r;
  logic need_plane_r;
  logic [7:0] dq_s;
  logic rb_s;
  logic [10:0] step;
  nfr_step_e sk;
  logic cyc_start;
  logic cyc_done;
  logic [7:0] cyc_rbyte;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic ctrl_wr;
  nfr_op_e new_op;
  logic refuse;

  // ------------------------------
  // pin synchronisers
  // ------------------------------
  nfr_sync3 #(.W(8), .RST_VAL(8'h00)) u_dq_sync (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .din(dq_i),
    .dout(dq_s)
  );

  nfr_sync3 #(.W(1), .RST_VAL(1'b0)) u_rb_sync (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .din(ready_busy_n),
    .dout(rb_s)
  );

  // ------------------------------
  // operation step table
  // ------------------------------
  // returns {kind, byte}; address bytes: col lo, col hi, row lo..hi
  function automatic logic [10:0] seq_step(
    input nfr_op_e op, input logic [3:0] i,
    input logic [15:0] c, input logic [23:0] r
  );
    logic [39:0] a0;
    logic [39:0] a1;
    logic [39:0] a2;
    logic [23:0] msk;
    nfr_step_e k;
    logic [7:0] b;
    int j;
    msk = 24'h000001 << PLANE_SELECT_BIT;
    a0 = {r & ~msk, c};
    a1 = {r | msk, c};
    a2 = {r, c};
    k = SK_END;
    b = 8'h00;
    j = int'(i);
    case (op)
      OP_RDMODE: begin
        if (i == 4'h0) begin
          k = SK_CMD;
          b = NC_READ;
        end
      end
      OP_PAGE, OP_CRAND: begin
        // (after 31h the device drops the column; 30h keeps it)
        if (i == 4'h0) begin
          k = SK_CMD;
          b = NC_READ;
        end else if (i <= 4'h5) begin
          k = SK_ADDR;
          b = a0[8*(j-1) +: 8];
        end else if (i == 4'h6) begin
          k = SK_CMD;
          b = (op == OP_PAGE) ? NC_PAGE_GO : NC_CACHE_GO;
        end else if (i == 4'h7) begin
          k = SK_WAIT;
        end
      end
      OP_TWOP: begin
        // (one column feeds both planes)
        if (i == 4'h0 || i == 4'h6) begin
          k = SK_CMD;
          b = NC_READ;
        end else if (i <= 4'h5) begin
          k = SK_ADDR;
          b = a0[8*(j-1) +: 8];
        end else if (i <= 4'hb) begin
          k = SK_ADDR;
          b = a1[8*(j-7) +: 8];
        end else if (i == 4'hc) begin
          k = SK_CMD;
          b = NC_PAGE_GO;
        end else if (i == 4'hd) begin
          k = SK_WAIT;
        end
      end
      OP_CSEQ, OP_CLAST: begin
        if (i == 4'h0) begin
          k = SK_CMD;
          b = (op == OP_CSEQ) ? NC_CACHE_GO : NC_CACHE_LAST;
        end else if (i == 4'h1) begin
          k = SK_WAIT;
        end
      end
      OP_COLMV: begin
        if (i == 4'h0) begin
          k = SK_CMD;
          b = NC_COL_MOVE;
        end else if (i <= 4'h2) begin
          k = SK_ADDR;
          b = a0[8*(j-1) +: 8];
        end else if (i == 4'h3) begin
          k = SK_CMD;
          b = NC_MOVE_GO;
        end
      end
      OP_PLMV: begin
        if (i == 4'h0) begin
          k = SK_CMD;
          b = NC_PLANE_MOVE;
        end else if (i <= 4'h5) begin
          k = SK_ADDR;
          b = a2[8*(j-1) +: 8];
        end else if (i == 4'h6) begin
          k = SK_CMD;
          b = NC_MOVE_GO;
        end
      end
      OP_STAT, OP_ECC: begin
        if (i == 4'h0) begin
          k = SK_CMD;
          b = NC_STATUS;
        end else if (i == 4'h1) begin
          k = SK_READ;
        end else if (i == 4'h2 && op == OP_ECC) begin
          k = SK_CMD; // back to data output
          b = NC_READ;
        end
      end
      OP_ESTAT: begin
        if (i == 4'h0) begin
          k = SK_CMD;
          b = NC_STATUS_SEL;
        end else if (i <= 4'h3) begin
          k = SK_ADDR;
          b = a0[8*(j+1) +: 8];
        end else if (i == 4'h4) begin
          k = SK_READ;
        end
      end
      OP_DATA: begin
        if (i == 4'h0) begin
          k = SK_READ;
        end
      end
      default: k = SK_END;
    endcase
    return {k, b};
  endfunction

  assign step = seq_step(op_r, idx_r, col_r, row_r);
  assign sk = nfr_step_e'(step[10:8]);
  assign cyc_start = (st_r == ST_ISSUE) && (sk == SK_CMD || sk == SK_ADDR || sk == SK_READ);

  nfr_bus_cycle u_cyc (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .start(cyc_start),
    .rd(sk == SK_READ),
    .is_addr(sk == SK_ADDR),
    .wbyte(step[7:0]),
    .done(cyc_done),
    .rbyte(cyc_rbyte),
    .cmd_latch(cmd_latch),
    .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_s(dq_s)
  );

  // ------------------------------
  // apb slave
  // ------------------------------
  // zero wait states; a frozen clock enable stalls the bus instead
  assign pready = clk_en;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_CFG) || (paddr == REG_COL) ||
                  (paddr == REG_ROW) || (paddr == REG_STAT) || (paddr == REG_DATA);
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite && mapped && clk_en;
  assign rd_setup = psel && !penable && !pwrite;
  assign ctrl_wr = wr_acc && (paddr == REG_CTRL);
  assign new_op = nfr_op_e'(pwdata[3:0]);

  // refusal in idle leaves the die untouched and sets refused_r until the next CTRL write; CTRL writes while busy are ignored
  always_comb begin
    refuse = (st_r != ST_IDLE) || (new_op > OP_DATA);
    if (!rb_s && new_op != OP_STAT && new_op != OP_ESTAT) begin
      refuse = 1'b1;
    end
    if (new_op == OP_RDMODE && cfg_r[CFG_MULTI_DIE] && !last_sel_r) begin
      refuse = 1'b1;
    end
    if (new_op == OP_DATA && (stat_out_r || need_plane_r)) begin
      refuse = 1'b1;
    end
    if (new_op == OP_ESTAT && two_plane_r) begin
      refuse = 1'b1;
    end
    if (new_op == OP_CSEQ && (&cur_row_r[DIE_ROW_BITS-1:0])) begin
      refuse = 1'b1;
    end
    if (new_op == OP_CRAND && row_r[23:DIE_ROW_BITS] != cur_row_r[23:DIE_ROW_BITS]) begin
      refuse = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_r <= CFG_RST;
      col_r <= 16'h0000;
      row_r <= 24'h000000;
    end else if (wr_acc) begin
      case (paddr)
        REG_CFG: cfg_r <= pwdata[1:0];
        REG_COL: col_r <= pwdata[15:0];
        REG_ROW: row_r <= pwdata[23:0];
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (clk_en && rd_setup) begin
      case (paddr)
        REG_CTRL: prdata <= {28'h0000000, op_r};
        REG_CFG: prdata <= {30'h00000000, cfg_r};
        REG_COL: prdata <= {16'h0000, col_r};
        REG_ROW: prdata <= {8'h00, row_r};
        REG_STAT: prdata <= {8'h00, data_r, status_r, 1'b0, two_plane_r, stat_out_r,
                             ecc_fail_r, rb_s, refused_r, done_r, (st_r != ST_IDLE)};
        REG_DATA: prdata <= {24'h000000, data_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------
  // sequencer
  // ------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= ST_IDLE;
      op_r <= OP_RDMODE;
      idx_r <= 4'h0;
      wb_r <= 4'h0;
      chip_en_n <= 1'b1;
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (clk_en) begin
      case (st_r)
        ST_IDLE: begin
          if (ctrl_wr) begin
            refused_r <= refuse;
            if (!refuse) begin
              done_r <= 1'b0;
              op_r <= new_op;
              idx_r <= 4'h0;
              chip_en_n <= 1'b0;
              st_r <= ST_ISSUE;
            end
          end
        end
        ST_ISSUE: begin
          if (sk == SK_END) begin
            st_r <= ST_FIN;
          end else if (sk == SK_WAIT) begin
            wb_r <= WB_CYC;
            st_r <= ST_WB;
          end else begin
            st_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (cyc_done) begin
            idx_r <= idx_r + 4'h1;
            st_r <= ST_ISSUE;
          end
        end
        ST_WB: begin
          // busy may lag the confirm command; ignore the pin until then
          if (wb_r == 4'h1) begin
            st_r <= ST_WRB;
          end else begin
            wb_r <= wb_r - 4'h1;
          end
        end
        ST_WRB: begin
          if (rb_s) begin
            idx_r <= idx_r + 4'h1;
            st_r <= ST_ISSUE;
          end
        end
        ST_FIN: begin
          if ((op_r == OP_PAGE || op_r == OP_TWOP) && cfg_r[CFG_ECC_EN]) begin
            op_r <= OP_ECC;
            idx_r <= 4'h0;
            st_r <= ST_ISSUE;
          end else begin
            done_r <= 1'b1;
            chip_en_n <= 1'b1;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------
  // read results
  // ------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= 8'h00;
      data_r <= 8'h00;
      ecc_fail_r <= 1'b0;
    end else if (clk_en && st_r == ST_XFER && cyc_done && sk == SK_READ) begin
      if (op_r == OP_DATA) begin
        data_r <= cyc_rbyte;
      end else begin
        status_r <= cyc_rbyte;
        if (op_r == OP_ECC) begin
          ecc_fail_r <= cyc_rbyte[STS_FAIL_BIT];
        end
      end
    end
  end

  // ------------------------------
  // die output mode tracking
  // ------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      last_sel_r <= 1'b0;
      stat_out_r <= 1'b0;
      two_plane_r <= 1'b0;
      need_plane_r <= 1'b0;
      cur_row_r <= 24'h000000;
    end else if (clk_en && st_r == ST_FIN && op_r != OP_DATA) begin
      last_sel_r <= (op_r == OP_ESTAT);
      case (op_r)
        OP_STAT, OP_ESTAT: begin
          stat_out_r <= 1'b1;
          need_plane_r <= need_plane_r || two_plane_r;
        end
        OP_PAGE: begin
          stat_out_r <= 1'b0;
          two_plane_r <= 1'b0;
          need_plane_r <= 1'b0;
          cur_row_r <= row_r;
        end
        OP_TWOP: begin
          stat_out_r <= 1'b0;
          two_plane_r <= 1'b1;
          need_plane_r <= 1'b0;
          cur_row_r <= row_r;
        end
        OP_CSEQ, OP_CRAND, OP_CLAST: begin
          stat_out_r <= cfg_r[CFG_MULTI_DIE];
          if (op_r == OP_CSEQ) begin
            cur_row_r <= cur_row_r + 24'h000001;
          end else if (op_r == OP_CRAND) begin
            cur_row_r <= row_r;
          end
        end
        OP_PLMV: begin
          stat_out_r <= 1'b0;
          need_plane_r <= 1'b0;
        end
        default: stat_out_r <= 1'b0; // read mode, column move, ecc check
      endcase
    end
  end
endmodule

// File: tb/nfr_host_assertions.sv
// Purpose: port-level checks of the nand read host
// Assumes: single clock, rst synchronous active high
// Notes: strobe widths follow the package cycle counts
`timescale 1ns/1ps
module nfr_host_assertions import nfr_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // nand pins
  input wire logic chip_en_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe
);
  // ------------------------------
  // sequences
  // ------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence we_pulse;
    !write_strobe_n ##1 write_strobe_n;
  endsequence
  sequence re_pulse;
    !output_strobe_n [*5] ##1 output_strobe_n;
  endsequence
  // ------------------------------
  // properties
  // ------------------------------
  zero_wait_a: assert property (pready == clk_en)
    else $error("pready not following clk_en");
  unmapped_error_a: assert property (psel && penable && paddr > REG_DATA |-> pslverr)
    else $error("unmapped access without error");
  mapped_clean_a: assert property (psel && penable && paddr == REG_STAT |-> !pslverr)
    else $error("mapped access flagged");
  latch_excl_a: assert property (!(cmd_latch && addr_latch))
    else $error("both latches high");
  idle_pins_a: assert property (chip_en_n |-> write_strobe_n && output_strobe_n && !dq_oe)
    else $error("pins active while deselected");
  write_pulse_a: assert property ($fell(write_strobe_n) |-> we_pulse)
    else $error("write strobe width wrong");
  write_drive_a: assert property (!write_strobe_n |-> dq_oe && (cmd_latch || addr_latch))
    else $error("write strobe without driven cycle");
  write_hold_a: assert property ($rose(write_strobe_n) |-> $stable(dq_o) && dq_oe)
    else $error("dq changed at strobe rise");
  read_pulse_a: assert property ($fell(output_strobe_n) |-> re_pulse)
    else $error("read strobe width wrong");
  read_release_a: assert property (!output_strobe_n |-> !dq_oe && write_strobe_n)
    else $error("host drives dq during read");
endmodule

bind nfr_host nfr_host_assertions i_chk (.clock, .rst, .clk_en, .paddr, .psel, .penable,
  .pready, .pslverr, .chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n,
  .output_strobe_n, .dq_o, .dq_oe);

// File: tb/nfr_dev_model.sv
// Purpose: behavioural nand die answering read commands
// Assumes: host strobes are clock-registered
// Notes: page byte equals column low byte
`timescale 1ns/1ps
module nfr_dev_model import nfr_pkg::*; #(
  parameter int BUSY_CYC = 20
) (
  // clock
  input wire logic clock,
  // nand pins
  input wire logic chip_en_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic [7:0] dq_o,
  output logic [7:0] dq_i,
  output logic ready_busy_n
);
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic stat_r = 1'b0;
  logic [2:0] acnt_r = 3'h0;
  logic [15:0] col_r = 16'h0000;
  logic [7:0] last_r = 8'h00;
  int busy_r = 0;
  assign ready_busy_n = (busy_r == 0);
  // released bus shows the inverse, never a stale byte
  assign dq_i = output_strobe_n ? ~last_r : (stat_r ? {1'b0, ready_busy_n, 6'h0} : col_r[7:0]);
  always @(posedge clock) begin
    we_q <= write_strobe_n;
    re_q <= output_strobe_n;
    if (busy_r > 0) busy_r <= busy_r - 1;
    if (!chip_en_n && write_strobe_n && !we_q && addr_latch) begin
      acnt_r <= acnt_r + 3'h1;
      if (acnt_r == 3'h0) col_r[7:0] <= dq_o;
      if (acnt_r == 3'h1) col_r[15:8] <= dq_o;
    end
    if (!chip_en_n && write_strobe_n && !we_q && cmd_latch) begin
      acnt_r <= 3'h0;
      case (dq_o)
        NC_STATUS, NC_STATUS_SEL: stat_r <= 1'b1;
        NC_READ: stat_r <= 1'b0;
        NC_PAGE_GO: busy_r <= BUSY_CYC;
        NC_CACHE_GO, NC_CACHE_LAST: begin
          busy_r <= BUSY_CYC;
          col_r <= 16'h0000;
        end
        default: ;
      endcase
    end
    if (!output_strobe_n) last_r <= dq_i;
    if (output_strobe_n && !re_q) begin
      if (!stat_r) col_r <= col_r + 16'h0001;
    end
  end
endmodule

// File: tb/tb.sv
// Purpose: apb-driven bench for the nand read host
// Assumes: die model answers on the far side
// Notes: each data op strobes one byte
`timescale 1ns/1ps
module tb import nfr_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, chip_en_n, cmd_latch, addr_latch;
  logic write_strobe_n, output_strobe_n, dq_oe, ready_busy_n;
  logic [7:0] dq_o, dq_i;
  logic [31:0] q;
  logic e;
  int errors = 0;
  int checked = 0;
  always #12.5 clock = ~clock;
  nfr_host i_dut (.clock, .rst, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n,
    .output_strobe_n, .dq_o, .dq_oe, .dq_i, .ready_busy_n);
  nfr_dev_model i_die (.clock, .chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n,
    .output_strobe_n, .dq_o, .dq_i, .ready_busy_n);
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic er);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  // status stays in q so refusals can be read back
  task automatic run_op(input logic [3:0] o);
    int n;
    n = 0;
    wr(REG_CTRL, {28'h0, o});
    do begin
      apb(1'b0, REG_STAT, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (n >= 500) errors++;
  endtask
  task automatic data(input logic [7:0] x);
    run_op(OP_DATA);
    apb(1'b0, REG_DATA, 32'h0, q, e);
    chk("data byte", 32'(q[7:0]), 32'(x));
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    #(25 * 20000);
    errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
    apb(1'b0, REG_CFG, 32'h0, q, e);
    chk("cfg reset", 32'(q[1:0]), 32'(CFG_RST));
    wr(REG_COL, 32'h5);
    wr(REG_ROW, 32'h3f);
    run_op(OP_PAGE);
    data(8'h05);
    data(8'h06);
    wr(REG_COL, 32'h20);
    run_op(OP_COLMV);
    data(8'h20);
    run_op(OP_CSEQ);
    data(8'h00);
    run_op(OP_CRAND);
    data(8'h00);
    run_op(OP_CLAST);
    data(8'h00);
    wr(REG_ROW, 32'h3ffff);
    run_op(OP_CRAND);
    data(8'h00);
    run_op(OP_CSEQ);
    chk("die edge refused", 32'(q[2]), 32'h1);
    wr(REG_ROW, 32'h3f);
    run_op(OP_STAT);
    chk("status byte", 32'(q[15:8]), 32'h40);
    run_op(OP_DATA);
    chk("data in status", 32'(q[2]), 32'h1);
    run_op(OP_RDMODE);
    data(8'h01);
    run_op(OP_ECC);
    chk("bad op refused", 32'(q[2]), 32'h1);
    wr(REG_COL, 32'h10);
    run_op(OP_TWOP);
    data(8'h10);
    wr(REG_COL, 32'h08);
    run_op(OP_PLMV);
    data(8'h08);
    run_op(OP_ESTAT);
    chk("enh after two-plane", 32'(q[2]), 32'h1);
    wr(REG_CFG, 32'h1);
    run_op(OP_RDMODE);
    chk("rdmode needs select", 32'(q[2]), 32'h1);
    run_op(OP_CLAST);
    run_op(OP_DATA);
    chk("data after multi cache", 32'(q[2]), 32'h1);
    wr(REG_CFG, 32'h2);
    wr(REG_COL, 32'h33);
    run_op(OP_PAGE);
    chk("ecc status byte", 32'(q[15:8]), 32'h40);
    chk("ecc fail flag", 32'(q[4]), 32'h0);
    data(8'h33);
    summarize();
  end
endmodule
